// >>> verilog/kps_top.sv
// Overview of operation
// - Status bit bit 3 reads the present keypad clock level.
// - Hardware scan enable set: columns are stepped automatically.
// - Hardware scan enable clear: bypass, no scanning, firmware drives.
// - Hardware mode: valid key sets detect flag and captures column, row.
// - Bypass: row falling edge after all rows high sets flag.
// - Reading the control/status register clears the detect flag.
// - Bypass edge detection works with keypad clock disabled.
// - Interrupt raised only while detect interrupt enable is set.
// - Detect flag sets regardless of interrupt enable.
// - Hardware mode: capture registers change only on a valid key.
// - Bypass: columns driven from column register, last value kept.
module kps_top
	import kps_pkg::*;
#(
	parameter int unsigned KCLK_HALF = KCLK_HALF_CYC
)(
	// Clock, reset, enable
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	// Wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [DAT_W-1:0] wb_dat_i,
	output logic      [DAT_W-1:0] wb_dat_o,
	output logic                  wb_ack_o,
	// Keypad matrix
	input  wire logic [ROW_W-1:0] row_i,
	output logic      [COL_W-1:0] col_o,
	// Interrupt
	output logic                  irq_o
);

	// -------------------------------------------------------------
	// Signals
	// -------------------------------------------------------------
	logic [ROW_W-1:0] row_s;
	logic [ROW_W-1:0] row_prev;
	logic             hardware_scan_enable;
	logic             key_detect_irq_enable;
	logic             key_detect_flag;
	logic             keypad_clock_level;
	logic             kclk_en;
	logic [15:0]      kclk_cnt;
	logic             kclk_tick;
	logic [COL_W-1:0] column_capture_register;
	logic [ROW_W-1:0] row_capture_register;
	logic [EVT_W-1:0] evt_stat;
	logic [EVT_W-1:0] evt_mask;
	kps_scan_e        state;
	logic [2:0]       col_idx;
	logic [3:0]       settle_cnt;
	logic             cap_fire;
	logic             rel_fire;
	logic             byp_edge;
	logic             wb_take;
	logic             wr_en;
	logic             rd_ctrl;
	logic             rd_evt;
	logic [7:0]       next_rdata;
	logic             next_irq;
	logic [COL_W-1:0] next_col;

	kps_rowsync u_rowsync (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.row_pin_i (row_i),
		.row_o     (row_s)
	);

	// -------------------------------------------------------------
	// Bus decode
	// -------------------------------------------------------------
	assign wb_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_en   = wb_take && wb_we_i && wb_sel_i[0];
	assign rd_ctrl = wb_take && !wb_we_i && (wb_adr_i == OFS_CTRL);
	assign rd_evt  = wb_take && !wb_we_i && (wb_adr_i == OFS_EVT);

	always_comb begin
		next_rdata = 8'h00;
		case (wb_adr_i)
			OFS_CTRL: begin
				next_rdata[BIT_CLKLVL] = keypad_clock_level;
				next_rdata[BIT_HWSCAN] = hardware_scan_enable;
				next_rdata[BIT_KEY_FLAG] = key_detect_flag;
				next_rdata[BIT_IRQEN]  = key_detect_irq_enable;
			end
			OFS_COL: next_rdata[COL_W-1:0] = column_capture_register;
			// Bypass reads the live rows so firmware can scan
			OFS_ROW: next_rdata[ROW_W-1:0] = hardware_scan_enable ?
				row_capture_register : row_s;
			OFS_CFG: next_rdata[BIT_KCLK_EN] = kclk_en;
			OFS_EVT: next_rdata[EVT_W-1:0] = evt_stat;
			OFS_MSK: next_rdata[EVT_W-1:0] = evt_mask;
			default: next_rdata = 8'h00;
		endcase
	end

	// Unmapped addresses still answer, with zero data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= wb_take;
			if (wb_take && !wb_we_i) begin
				wb_dat_o <= {24'h000000, next_rdata};
			end
		end
	end

	// -------------------------------------------------------------
	// Control bits
	// -------------------------------------------------------------
	// Only bits 2 and 0 are stored; bits 7..4 have no storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hardware_scan_enable  <= RST_HWSCAN;
			key_detect_irq_enable <= RST_IRQEN;
			kclk_en               <= RST_KCLK_EN;
			evt_mask              <= RST_EVT;
		end else if (ce_i && wr_en) begin
			case (wb_adr_i)
				OFS_CTRL: begin
					hardware_scan_enable  <= wb_dat_i[BIT_HWSCAN];
					key_detect_irq_enable <= wb_dat_i[BIT_IRQEN];
				end
				OFS_CFG: kclk_en  <= wb_dat_i[BIT_KCLK_EN];
				OFS_MSK: evt_mask <= wb_dat_i[EVT_W-1:0];
				default: ;
			endcase
		end
	end

	// -------------------------------------------------------------
	// Keypad interface clock
	// -------------------------------------------------------------
	assign kclk_tick = kclk_en && !keypad_clock_level &&
		(kclk_cnt == 16'(KCLK_HALF - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			kclk_cnt           <= 16'h0000;
			keypad_clock_level <= 1'b0;
		end else if (ce_i && kclk_en) begin
			if (kclk_cnt == 16'(KCLK_HALF - 1)) begin
				kclk_cnt           <= 16'h0000;
				keypad_clock_level <= !keypad_clock_level;
			end else begin
				kclk_cnt <= 16'(kclk_cnt + 16'h0001);
			end
		end
	end

	// -------------------------------------------------------------
	// Automatic scanner
	// -------------------------------------------------------------
	// Scanning pauses, not aborts, while the keypad clock is stopped
	assign cap_fire = (state == ST_SCAN) && kclk_tick &&
		!kps_all_high(row_s);
	assign rel_fire = (state == ST_HOLD) && kclk_tick &&
		kps_all_high(row_s);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state      <= ST_IDLE;
			col_idx    <= 3'h0;
			settle_cnt <= 4'h0;
		end else if (ce_i) begin
			if (!hardware_scan_enable) begin
				state <= ST_IDLE;
			end else if (kclk_tick) begin
				case (state)
					ST_IDLE: begin
						if (!kps_all_high(row_s)) begin
							state   <= ST_SCAN;
							col_idx <= 3'h0;
						end
					end
					ST_SCAN: begin
						if (!kps_all_high(row_s)) begin
							state <= ST_HOLD;
						end else if (col_idx == 3'(COL_W - 1)) begin
							state <= ST_IDLE;
						end else begin
							col_idx <= 3'(col_idx + 3'h1);
						end
					end
					ST_HOLD: begin
						if (kps_all_high(row_s)) begin
							state      <= ST_SETTLE;
							settle_cnt <= 4'h0;
						end
					end
					ST_SETTLE: begin
						// A bounce restarts the settle time
						if (!kps_all_high(row_s)) begin
							settle_cnt <= 4'h0;
						end else if (settle_cnt == SETTLE_TICKS - 4'h1) begin
							state <= ST_IDLE;
						end else begin
							settle_cnt <= 4'(settle_cnt + 4'h1);
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// Capture registers
	// -------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			column_capture_register <= RST_COL;
			row_capture_register    <= RST_ROW;
		end else if (ce_i) begin
			if (hardware_scan_enable) begin
				if (cap_fire) begin
					column_capture_register <= kps_col_drive(col_idx);
					row_capture_register    <= row_s;
				end
			end else if (wr_en && wb_adr_i == OFS_COL) begin
				column_capture_register <= wb_dat_i[COL_W-1:0];
			end
		end
	end

	always_comb begin
		case (state)
			ST_SCAN: next_col = kps_col_drive(col_idx);
			default: next_col = {COL_W{1'b0}};
		endcase
		if (!hardware_scan_enable) begin
			next_col = column_capture_register;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			col_o <= RST_COL;
		end else if (ce_i) begin
			col_o <= next_col;
		end
	end

	// -------------------------------------------------------------
	// Key detect and events
	// -------------------------------------------------------------
	// Core clock only, so bypass detect survives a stopped keypad clock
	assign byp_edge = !hardware_scan_enable && kps_all_high(row_prev) &&
		!kps_all_high(row_s);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			row_prev <= RST_ROW;
		end else if (ce_i) begin
			row_prev <= row_s;
		end
	end

	// Set wins over the read clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			key_detect_flag <= 1'b0;
		end else if (ce_i) begin
			if (cap_fire || byp_edge) begin
				key_detect_flag <= 1'b1;
			end else if (rd_ctrl) begin
				key_detect_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_stat <= RST_EVT;
		end else if (ce_i) begin
			for (int i = 0; i < EVT_W; i++) begin
				if ((i == BIT_EVT_PRESS) ? (cap_fire || byp_edge) :
					rel_fire) begin
					evt_stat[i] <= 1'b1;
				end else if (rd_evt) begin
					evt_stat[i] <= 1'b0;
				end
			end
		end
	end

	assign next_irq = key_detect_irq_enable &&
		(key_detect_flag || |(evt_stat & evt_mask));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= next_irq;
		end
	end

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_press_found;
		ce_i && hardware_scan_enable && cap_fire;
	endsequence
	sequence s_flag_up;
		ce_i [*1] ##1 key_detect_flag;
	endsequence

	a_clock_level_read: assert property (
		ce_i && rd_ctrl |=> wb_ack_o &&
			wb_dat_o[BIT_CLKLVL] == $past(keypad_clock_level))
		else $error("clock level bit not returned on read");
	a_scan_one_column: assert property (
		ce_i && hardware_scan_enable && state == ST_SCAN |=>
			!ce_i || !$past(hardware_scan_enable) ||
			$countones(col_o) == COL_W - 1)
		else $error("scan does not drive exactly one column low");
	a_bypass_no_scan: assert property (
		ce_i && !hardware_scan_enable |=> state == ST_IDLE)
		else $error("scanner active in bypass mode");
	a_hw_detect_sets: assert property (
		s_press_found |=> key_detect_flag &&
			row_capture_register == $past(row_s))
		else $error("valid key did not set flag and capture row");
	a_bypass_edge_set: assert property (
		ce_i && !hardware_scan_enable && &row_prev && !(&row_s)
			|-> s_flag_up)
		else $error("row falling edge did not set detect flag");
	a_read_clears: assert property (
		ce_i && rd_ctrl && !cap_fire && !byp_edge |=> !key_detect_flag)
		else $error("status read did not clear detect flag");
	a_no_kclk_detect: assert property (
		ce_i && !kclk_en && byp_edge |=> key_detect_flag ##1
			(!$past(ce_i) || !$past(key_detect_irq_enable) ||
			irq_o))
		else $error("bypass detect lost with keypad clock off");
	a_irq_gated: assert property (
		ce_i |=> irq_o == ($past(key_detect_irq_enable) &&
			($past(key_detect_flag) || |($past(evt_stat & evt_mask)))))
		else $error("interrupt not gated by enable");
	a_flag_unmasked: assert property (
		ce_i && !key_detect_irq_enable && (cap_fire || byp_edge)
			|=> key_detect_flag && !irq_o)
		else $error("flag not set while interrupt disabled");
	a_capture_only_valid: assert property (
		ce_i && hardware_scan_enable && !cap_fire |=>
			$stable(row_capture_register) &&
			$stable(column_capture_register))
		else $error("capture changed without a valid key");
	a_bypass_columns: assert property (
		ce_i && !hardware_scan_enable |=>
			col_o == $past(column_capture_register))
		else $error("bypass columns differ from column register");
	a_upper_zero: assert property (
		ce_i && rd_ctrl |=> wb_dat_o[7:4] == 4'h0)
		else $error("reserved status bits not zero");

endmodule

// >>> verilog/kps_pkg.sv
package kps_pkg;

	// -------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned KCLK_HZ       = 1000;
	localparam int unsigned KCLK_HALF_CYC = CLK_HZ / (2 * KCLK_HZ);
	localparam logic [3:0]  SETTLE_TICKS  = 4'h4;

	// -------------------------------------------------------------
	// Widths
	// -------------------------------------------------------------
	localparam int COL_W = 5;
	localparam int ROW_W = 6;
	localparam int DAT_W = 32;
	localparam int ADR_W = 5;

	// -------------------------------------------------------------
	// Register offsets (byte addresses)
	// -------------------------------------------------------------
	localparam logic [ADR_W-1:0] OFS_CTRL = 5'h00;
	localparam logic [ADR_W-1:0] OFS_COL  = 5'h04;
	localparam logic [ADR_W-1:0] OFS_ROW  = 5'h08;
	localparam logic [ADR_W-1:0] OFS_CFG  = 5'h0c;
	localparam logic [ADR_W-1:0] OFS_EVT  = 5'h10;
	localparam logic [ADR_W-1:0] OFS_MSK  = 5'h14;

	// -------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------
	localparam int BIT_CLKLVL    = 3;
	localparam int BIT_HWSCAN    = 2;
	localparam int BIT_KEY_FLAG  = 1;
	localparam int BIT_IRQEN     = 0;
	localparam int BIT_KCLK_EN   = 0;
	localparam int BIT_EVT_PRESS = 0;
	localparam int BIT_EVT_REL   = 1;
	localparam int EVT_W         = 2;

	// -------------------------------------------------------------
	// Reset values
	// -------------------------------------------------------------
	localparam logic             RST_HWSCAN  = 1'b0;
	localparam logic             RST_IRQEN   = 1'b0;
	localparam logic             RST_KCLK_EN = 1'b1;
	localparam logic [COL_W-1:0] RST_COL     = 5'h1f;
	localparam logic [ROW_W-1:0] RST_ROW     = 6'h3f;
	localparam logic [EVT_W-1:0] RST_EVT     = 2'h0;

	typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_HOLD, ST_SETTLE}
		kps_scan_e;

	function automatic logic kps_all_high(input logic [ROW_W-1:0] r);
		return &r;
	endfunction

	// One column low, the others high
	function automatic logic [COL_W-1:0] kps_col_drive(
		input logic [2:0] idx);
		logic [COL_W-1:0] v;
		v = ~(COL_W'(1) << idx);
		return v;
	endfunction

endpackage

// >>> verilog/kps_rowsync.sv
module kps_rowsync
	import kps_pkg::*;
(
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	// Pins and result
	input  wire logic [ROW_W-1:0] row_pin_i,
	output logic      [ROW_W-1:0] row_o
);

	logic [ROW_W-1:0] ff1;
	logic [ROW_W-1:0] ff2;
	logic [ROW_W-1:0] ff3;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ff1 <= RST_ROW;
			ff2 <= RST_ROW;
			ff3 <= RST_ROW;
		end else if (ce_i) begin
			ff1 <= row_pin_i;
			ff2 <= ff1;
			ff3 <= ff2;
		end
	end

	// A bit moves only once the last two stages agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			row_o <= RST_ROW;
		end else if (ce_i) begin
			for (int i = 0; i < ROW_W; i++) begin
				if (ff2[i] == ff3[i]) begin
					row_o[i] <= ff3[i];
				end
			end
		end
	end

endmodule

// >>> testbench/kps_keypad_model.sv
module kps_keypad_model
	import kps_pkg::*;
(
	// Key under test
	input  wire logic             press_i,
	input  wire logic [2:0]       key_col_i,
	input  wire logic [2:0]       key_row_i,
	// Matrix lines
	input  wire logic [COL_W-1:0] col_i,
	output logic      [ROW_W-1:0] row_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// -------------------------------------------------------------
	// Switch matrix
	// -------------------------------------------------------------
	// Rows have pull-ups, so a released line reads high, never stale
	always_comb begin
		row_o = {ROW_W{1'b1}};
		if (press_i && col_i[key_col_i] === 1'b0) begin
			row_o[key_row_i] = 1'b0;
		end
	end
endmodule

// >>> testbench/tb.sv
module tb
	import kps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// -------------------------------------------------------------
	// Signals
	// -------------------------------------------------------------
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             ce    = 1'b1;
	logic             cyc   = 1'b0;
	logic             stb   = 1'b0;
	logic             we    = 1'b0;
	logic [ADR_W-1:0] adr   = '0;
	logic [3:0]       sel   = 4'h0;
	logic [DAT_W-1:0] wdat  = '0;
	logic [DAT_W-1:0] rdat;
	logic             ack;
	logic [ROW_W-1:0] row;
	logic [COL_W-1:0] col;
	logic             irq;
	logic             press = 1'b0;
	logic [2:0]       kc    = 3'h0;
	logic [2:0]       kr    = 3'h0;
	int               err_total = 0;
	int               num_checks = 0;
	logic [DAT_W-1:0] q;

	always #50 clk_i = ~clk_i;

	kps_top #(.KCLK_HALF(4)) i_kps_top (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack),
		.row_i(row), .col_o(col), .irq_o(irq));

	kps_keypad_model i_kps_keypad_model (
		.press_i(press), .key_col_i(kc), .key_row_i(kr),
		.col_i(col), .row_o(row));

	// -------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: %s got %h", $time, m, g);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Ack is sampled at the edge; read data taken at that same edge
	task automatic wb(input logic w, input logic [ADR_W-1:0] a,
		input logic [7:0] d, output logic [DAT_W-1:0] r);
		int n;
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= 4'hf;
		wdat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		chk(32'(n), 32'h2, "bus answer");
	endtask

	task automatic wr(input logic [ADR_W-1:0] a, input logic [7:0] d);
		logic [DAT_W-1:0] r;
		wb(1'b1, a, d, r);
	endtask

	// -------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------
	task automatic t_reset;
		wb(1'b0, OFS_CTRL, 8'h0, q);
		chk(q & 32'hf7, 32'h0, "ctrl reset");
		wb(1'b0, OFS_COL, 8'h0, q);
		chk(q, 32'h1f, "col reset");
		wb(1'b0, OFS_ROW, 8'h0, q);
		chk(q, 32'h3f, "row reset");
		wb(1'b0, OFS_CFG, 8'h0, q);
		chk(q, 32'h01, "cfg reset");
		wb(1'b0, 5'h18, 8'h0, q);
		chk(q, 32'h0, "unmapped read");
		chk(32'(col), 32'h1f, "col pins idle");
		wr(OFS_CTRL, 8'hf0);
		wb(1'b0, OFS_CTRL, 8'h0, q);
		chk(q & 32'hf7, 32'h0, "upper bits");
		$display("test reset done");
	endtask

	task automatic t_clk;
		logic s0;
		logic s1;
		logic b;
		s0 = 1'b0;
		s1 = 1'b0;
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, OFS_CTRL, 8'h0, q);
			s0 |= (q[BIT_CLKLVL] === 1'b0);
			s1 |= (q[BIT_CLKLVL] === 1'b1);
		end
		chk(32'(s0 & s1), 32'h1, "clock level moves");
		wr(OFS_CFG, 8'h00);
		wb(1'b0, OFS_CTRL, 8'h0, q);
		b = q[BIT_CLKLVL];
		repeat (10) @(posedge clk_i);
		wb(1'b0, OFS_CTRL, 8'h0, q);
		chk(32'(q[BIT_CLKLVL]), 32'(b), "clock level frozen");
		$display("test clock level done");
	endtask

	// Keypad clock left disabled here on purpose
	task automatic t_bypass;
		wr(OFS_COL, 8'h1e);
		kc    <= 3'h0;
		kr    <= 3'h2;
		press <= 1'b1;
		repeat (12) @(posedge clk_i);
		chk(32'(col), 32'h1e, "bypass col pins");
		chk(32'(irq), 32'h0, "irq masked");
		wb(1'b0, OFS_ROW, 8'h0, q);
		chk(q, 32'h3b, "live rows");
		wb(1'b0, OFS_CTRL, 8'h0, q);
		chk(32'(q[BIT_KEY_FLAG]), 32'h1, "flag set");
		wb(1'b0, OFS_CTRL, 8'h0, q);
		chk(32'(q[BIT_KEY_FLAG]), 32'h0, "flag cleared");
		press <= 1'b0;
		repeat (12) @(posedge clk_i);
		wr(OFS_CTRL, 8'h01);
		// Enable low: the press must wait until the block runs again
		ce    <= 1'b0;
		press <= 1'b1;
		repeat (12) @(posedge clk_i);
		chk(32'(irq), 32'h0, "frozen by enable");
		ce    <= 1'b1;
		repeat (12) @(posedge clk_i);
		chk(32'(irq), 32'h1, "irq raised");
		wb(1'b0, OFS_CTRL, 8'h0, q);
		chk(32'(q[BIT_KEY_FLAG]), 32'h1, "flag with irq");
		repeat (2) @(posedge clk_i);
		chk(32'(irq), 32'h0, "irq cleared");
		press <= 1'b0;
		repeat (12) @(posedge clk_i);
		$display("test bypass done");
	endtask

	task automatic t_hw;
		logic stepped;
		int n;
		stepped = 1'b0;
		wr(OFS_CFG, 8'h01);
		wr(OFS_CTRL, 8'h05);
		repeat (4) @(posedge clk_i);
		chk(32'(col), 32'h00, "idle all columns");
		wb(1'b0, OFS_COL, 8'h0, q);
		chk(q, 32'h1e, "capture untouched");
		kc    <= 3'h2;
		kr    <= 3'h3;
		press <= 1'b1;
		for (n = 0; n < 300 && irq !== 1'b1; n++) begin
			@(posedge clk_i);
			stepped |= (col === 5'h1e);
		end
		chk(32'(stepped), 32'h1, "columns stepped");
		chk(32'(irq), 32'h1, "hw key irq");
		wb(1'b0, OFS_COL, 8'h0, q);
		chk(q, 32'h1b, "captured col");
		wb(1'b0, OFS_ROW, 8'h0, q);
		chk(q, 32'h37, "captured row");
		wb(1'b0, OFS_CTRL, 8'h0, q);
		chk(q & 32'h7, 32'h7, "hw flag");
		// Only the release event is unmasked from here on
		wr(OFS_MSK, 8'h02);
		wb(1'b0, OFS_MSK, 8'h0, q);
		chk(q, 32'h02, "mask readback");
		chk(32'(irq), 32'h0, "press event masked");
		press <= 1'b0;
		for (n = 0; n < 300 && irq !== 1'b1; n++) begin
			@(posedge clk_i);
		end
		chk(32'(irq), 32'h1, "release irq");
		wb(1'b0, OFS_EVT, 8'h0, q);
		chk(q, 32'h03, "press and release events");
		repeat (2) @(posedge clk_i);
		chk(32'(irq), 32'h0, "events cleared");
		wb(1'b0, OFS_EVT, 8'h0, q);
		chk(q, 32'h00, "events read clear");
		$display("test hardware scan done");
	endtask

	// -------------------------------------------------------------
	// Sequence and watchdog
	// -------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_clk();
		t_bypass();
		t_hw();
		results();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		results();
	end
endmodule
